// ==== core/atm_map.vh ====
`ifndef ATM_MAP_VH
`define ATM_MAP_VH
`define ATM_ADDR_W        16
`define ATM_OFS_CMD       16'h1800
`define ATM_OFS_WR_LOW    16'h1801
`define ATM_OFS_WR_HIGH   16'h1802
`define ATM_OFS_RD_LOW    16'h1803
`define ATM_OFS_RD_HIGH   16'h1804
`define ATM_OFS_CMD_STS   16'h1805
`define ATM_BIT_MAKE      2
`define ATM_BIT_FIRST     1
`define ATM_BIT_NEXT      0
`define ATM_BIT_VALID     24
`define ATM_BIT_AGE       23
`define ATM_BIT_STATIC    22
`define ATM_BIT_FILTER    21
`define ATM_PRIO_HI       20
`define ATM_PRIO_LO       19
`define ATM_PORT_HI       18
`define ATM_PORT_LO       16
`define ATM_HIGH_MASK     32'h01FFFFFF
`define ATM_STS_MAKE_PEND 0
`define ATM_STS_SEARCH_PEND 1
`define ATM_STS_FOUND     2
`define ATM_STS_END       3
`define ATM_ENTRIES       8
`define ATM_IDX_W         3
`define ATM_CMD_RESET     32'h00000000
`define ATM_WR_RESET      32'h00000000
`endif

// ==== core/atm_table.v ====
`timescale 1ns/1ns
`include "atm_map.vh"
module atm_table (
  input  wire        i_clock,
  input  wire        i_sys_rst,
  input  wire [15:0] i_addr,
  input  wire [31:0] i_wdata,
  input  wire        i_wr,
  input  wire        i_rd,
  output reg  [31:0] o_rdata,
  output reg         o_make_busy,
  output reg         o_search_busy
);
  localparam [3:0] ST_IDLE = 4'h1;
  localparam [3:0] ST_MAKE = 4'h2;
  localparam [3:0] ST_SRCH = 4'h4;
  localparam [3:0] ST_DONE = 4'h8;
  localparam       N       = `ATM_ENTRIES;
  localparam       IW      = `ATM_IDX_W;

  reg  [3:0]    state_q;
  reg  [3:0]    state_d;
  reg  [2:0]    cmd_q;
  reg  [31:0]   wr_low_q;
  reg  [24:0]   wr_high_q;
  reg  [31:0]   rd_low_q;
  reg  [24:0]   rd_high_q;
  reg  [IW-1:0] ptr_q;
  reg  [IW:0]   scan_q;
  reg  [IW:0]   scan_d;
  reg           found_q;
  reg           end_q;
  reg           mpend_q;
  reg           spend_q;
  reg  [31:0]   rdata_d;
  reg  [N-1:0]  free_oh;
  reg  [N-1:0]  hit_oh;
  reg  [N-1:0]  slot_oh;
  reg           free_ok;
  reg           hit_ok;
  reg           slot_ok;

  // Host register decode
  wire wr_cmd  = i_wr && (i_addr == `ATM_OFS_CMD);
  wire wr_low  = i_wr && (i_addr == `ATM_OFS_WR_LOW);
  wire wr_high = i_wr && (i_addr == `ATM_OFS_WR_HIGH);

  // Only a 0 to 1 step of a command bit starts work
  wire make_go  = wr_cmd && i_wdata[`ATM_BIT_MAKE] &&
                  !cmd_q[`ATM_BIT_MAKE];
  wire first_go = wr_cmd && i_wdata[`ATM_BIT_FIRST] &&
                  !cmd_q[`ATM_BIT_FIRST];
  wire next_go  = wr_cmd && i_wdata[`ATM_BIT_NEXT] &&
                  !cmd_q[`ATM_BIT_NEXT];

  // A start while busy is lost; software polls status first
  wire idle_now    = (state_q == ST_IDLE);
  wire start_make  = idle_now && make_go;
  wire start_first = idle_now && first_go && !make_go;
  wire start_next  = idle_now && next_go && !make_go && !first_go;
  wire in_make     = (state_q == ST_MAKE);
  wire in_srch     = (state_q == ST_SRCH);

  // Table storage and match, one generate step per entry
  wire [31:0]  ent_low  [0:N-1];
  wire [24:0]  ent_high [0:N-1];
  wire [N-1:0] vld;
  wire [N-1:0] hit;
  wire [N-1:0] ent_we;
  genvar g;
  generate
    for (g = 0; g < N; g = g + 1) begin : g_ent
      reg [31:0] low_q;
      reg [24:0] high_q;
      assign ent_we[g] = in_make && slot_ok && slot_oh[g];
      always @(posedge i_clock) begin
        if (i_sys_rst) begin
          low_q  <= 32'h00000000;
          high_q <= 25'h0000000;
        end else if (ent_we[g]) begin
          low_q <= wr_low_q;
          if (wr_high_q[`ATM_BIT_VALID]) begin
            high_q <= wr_high_q;
          end else begin
            // Removal wipes every flag, static included
            high_q <= 25'h0000000;
          end
        end
      end
      assign ent_low[g]  = low_q;
      assign ent_high[g] = high_q;
      assign vld[g]      = high_q[`ATM_BIT_VALID];
      assign hit[g]      = vld[g] && (low_q == wr_low_q) &&
                           (high_q[15:0] == wr_high_q[15:0]);
    end
  endgenerate

  wire [IW-1:0] scan_idx = scan_q[IW-1:0];
  wire          scan_end = scan_q[IW];
  wire          scan_hit = !scan_end && vld[scan_idx];

  // Slot choice: a matching entry first, else the lowest free one
  integer k;
  always @* begin
    free_oh = {N{1'b0}};
    hit_oh  = {N{1'b0}};
    free_ok = 1'b0;
    hit_ok  = 1'b0;
    for (k = 0; k < N; k = k + 1) begin
      if (!vld[k] && !free_ok) begin
        free_oh[k] = 1'b1;
        free_ok    = 1'b1;
      end
      if (hit[k] && !hit_ok) begin
        hit_oh[k] = 1'b1;
        hit_ok    = 1'b1;
      end
    end
    if (hit_ok) begin
      slot_oh = hit_oh;
    end else begin
      slot_oh = free_oh;
    end
    // Full table and no match: the entry is dropped
    slot_ok = hit_ok || free_ok;
  end

  // Write data and command registers
  always @(posedge i_clock) begin
    if (i_sys_rst) begin
      cmd_q     <= 3'h0;
      wr_low_q  <= `ATM_WR_RESET;
      wr_high_q <= 25'h0000000;
    end else begin
      if (wr_cmd) begin
        cmd_q <= i_wdata[2:0];
      end
      if (wr_low) begin
        wr_low_q <= i_wdata;
      end
      if (wr_high) begin
        wr_high_q <= i_wdata[24:0];
      end
    end
  end

  // Control state
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (start_make) begin
          state_d = ST_MAKE;
        end else if (start_first || start_next) begin
          state_d = ST_SRCH;
        end
      end
      ST_MAKE: begin
        state_d = ST_DONE;
      end
      ST_SRCH: begin
        if (scan_end || scan_hit) begin
          state_d = ST_DONE;
        end
      end
      ST_DONE: begin
        state_d = ST_IDLE;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always @(posedge i_clock) begin
    if (i_sys_rst) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // One slot per clock keeps the search small
  always @* begin
    scan_d = scan_q;
    if (start_first) begin
      scan_d = {(IW+1){1'b0}};
    end else if (start_next) begin
      scan_d = {1'b0, ptr_q} + 1'b1;
    end else if (in_srch && !scan_end && !scan_hit) begin
      scan_d = scan_q + 1'b1;
    end
  end

  always @(posedge i_clock) begin
    if (i_sys_rst) begin
      scan_q <= {(IW+1){1'b0}};
    end else begin
      scan_q <= scan_d;
    end
  end

  // Read pointer and read words; a miss keeps the old words
  always @(posedge i_clock) begin
    if (i_sys_rst) begin
      ptr_q     <= {IW{1'b0}};
      rd_low_q  <= 32'h00000000;
      rd_high_q <= 25'h0000000;
    end else if (in_srch && scan_hit) begin
      ptr_q     <= scan_idx;
      rd_low_q  <= ent_low[scan_idx];
      rd_high_q <= ent_high[scan_idx];
    end
  end

  // Pending flags are set by a command and cleared by hardware; found and end clear on the next search command
  always @(posedge i_clock) begin
    if (i_sys_rst) begin
      mpend_q <= 1'b0;
      spend_q <= 1'b0;
      found_q <= 1'b0;
      end_q   <= 1'b0;
    end else begin
      if (start_make) begin
        mpend_q <= 1'b1;
      end else if (in_make) begin
        mpend_q <= 1'b0;
      end
      if (start_first || start_next) begin
        spend_q <= 1'b1;
        found_q <= 1'b0;
        end_q   <= 1'b0;
      end else if (in_srch && scan_end) begin
        spend_q <= 1'b0;
        end_q   <= 1'b1;
      end else if (in_srch && scan_hit) begin
        spend_q <= 1'b0;
        found_q <= 1'b1;
      end
    end
  end

  // Port field decode, shown on the read side as given
  wire [2:0] rd_port  = rd_high_q[`ATM_PORT_HI:`ATM_PORT_LO];
  wire       rd_multi = rd_port[2];

  // Read mux; reserved and unmapped bits read zero
  always @* begin
    rdata_d = 32'h00000000;
    case (i_addr)
      `ATM_OFS_CMD: begin
        rdata_d = {29'h0, cmd_q};
      end
      `ATM_OFS_WR_LOW: begin
        rdata_d = wr_low_q;
      end
      `ATM_OFS_WR_HIGH: begin
        rdata_d = {7'h00, wr_high_q};
      end
      `ATM_OFS_RD_LOW: begin
        rdata_d = rd_low_q;
      end
      `ATM_OFS_RD_HIGH: begin
        rdata_d = {7'h00, rd_high_q[24:19], rd_multi, rd_port[1:0],
                   rd_high_q[15:0]};
      end
      `ATM_OFS_CMD_STS: begin
        rdata_d = {28'h0, end_q, found_q, spend_q, mpend_q};
      end
      default: begin
        rdata_d = 32'h00000000;
      end
    endcase
  end

  always @(posedge i_clock) begin
    if (i_sys_rst) begin
      o_rdata       <= 32'h00000000;
      o_make_busy   <= 1'b0;
      o_search_busy <= 1'b0;
    end else begin
      o_make_busy   <= mpend_q;
      o_search_busy <= spend_q;
      if (i_rd) begin
        o_rdata <= rdata_d;
      end else begin
        o_rdata <= 32'h00000000;
      end
    end
  end
endmodule // atm_table

// ==== verification/atm_table_properties.sv ====
`timescale 1ns/1ns
module atm_chk (
  input wire        i_clock,
  input wire        i_sys_rst,
  input wire [15:0] i_addr,
  input wire [31:0] i_wdata,
  input wire        i_wr,
  input wire        i_rd,
  input wire [31:0] o_rdata,
  input wire        o_make_busy,
  input wire        o_search_busy
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);
  wire cw   = i_wr && i_addr == 16'h1800;
  wire idle = !o_make_busy && !o_search_busy;
  sequence s_done; o_make_busy ##1 !o_make_busy; endsequence
  chk_rdata_idle: assert property (!i_rd |=> o_rdata == 32'h0)
    else $error("read data not zero");
  chk_cmd_resvd: assert property (i_rd && i_addr == 16'h1800
    |=> o_rdata[31:3] == 29'h0) else $error("command reserved set");
  chk_high_resvd: assert property (i_rd && i_addr == 16'h1804
    |=> o_rdata[31:25] == 7'h0) else $error("read high reserved set");
  chk_make_cause: assert property ($rose(o_make_busy)
    |-> $past(cw && i_wdata[2], 2)) else $error("make without command");
  chk_make_short: assert property ($rose(o_make_busy) |-> s_done)
    else $error("make too long");
  chk_search_cause: assert property ($rose(o_search_busy)
    |-> $past(cw) || $past(cw, 2)) else $error("search without command");
  chk_search_end: assert property (o_search_busy
    |-> ##[1:12] !o_search_busy) else $error("search hung");
  chk_zero_noop: assert property (idle && !$past(i_wr) && cw
    && i_wdata[2:0] == 3'h0 |=> idle [*2]) else $error("zero write acted");
endmodule // atm_chk
bind atm_table atm_chk u_chk (.i_clock(i_clock), .i_sys_rst(i_sys_rst),
  .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
  .o_rdata(o_rdata), .o_make_busy(o_make_busy),
  .o_search_busy(o_search_busy));

// ==== verification/atm_host.sv ====
`timescale 1ns/1ns
module atm_host (
  input  wire        i_clock,
  input  wire [31:0] i_rdata,
  output reg  [15:0] o_addr,
  output reg  [31:0] o_wdata,
  output reg         o_wr,
  output reg         o_rd
);
  initial {o_addr, o_wdata, o_wr, o_rd} = 50'h0;
  task wr(input [15:0] a, input [31:0] d);
    @(posedge i_clock);
    {o_addr, o_wdata, o_wr} <= {a, d, 1'b1};
    @(posedge i_clock);
    o_wr <= 1'b0;
  endtask
  // Data stands only in the cycle after the strobe; taken at its end
  task rd(input [15:0] a, output [31:0] d);
    @(posedge i_clock);
    {o_addr, o_rd} <= {a, 1'b1};
    @(posedge i_clock);
    o_rd <= 1'b0;
    @(posedge i_clock);
    d = i_rdata;
  endtask
  task poll(input [1:0] b);
    reg [31:0] s;
    s = 32'hFFFFFFFF;
    repeat (20) if (s[b]) rd(16'h1805, s);
  endtask
  task make(input [31:0] lo, input [31:0] hi);
    wr(16'h1801, lo);
    wr(16'h1802, hi);
    wr(16'h1800, 32'h00000004);
    poll(0);
    wr(16'h1800, 32'h00000000);
  endtask
  task find(input [31:0] c, output [31:0] lo, output [31:0] hi);
    wr(16'h1800, c);
    poll(1);
    rd(16'h1803, lo);
    rd(16'h1804, hi);
    wr(16'h1800, 32'h00000000);
  endtask
endmodule // atm_host

// ==== verification/address_table_manual_access_test.sv ====
`timescale 1ns/1ns
`define CHK(n, e, s) begin samples_checked++; if ((s) !== (e)) begin \
  num_errors++; $display("[FAIL] %s exp %h got %h", n, e, s); end end
module address_table_manual_access_test;
  reg         clock;
  reg         rst = 1'b1;
  wire [15:0] addr;
  wire [31:0] wdata, rdata;
  wire        wr, rd, mb, sb;
  int         num_errors = 0, samples_checked = 0, cycles = 0;
  reg  [31:0] lo, hi, l2, h2;
  reg         ok;
  localparam [31:0] AL = 32'h12345678, AH = 32'h01410ABC;
  localparam [31:0] BL = 32'h00000001, BH = 32'h01440002;
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  atm_host host (.i_clock(clock), .i_rdata(rdata), .o_addr(addr),
    .o_wdata(wdata), .o_wr(wr), .o_rd(rd));
  atm_table uut (.i_clock(clock), .i_sys_rst(rst), .i_addr(addr),
    .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
    .o_make_busy(mb), .o_search_busy(sb));
  task end_of_test;
    if (num_errors == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      end_of_test();
    end
  end
  task t_reset;
    host.rd(16'h1800, lo); `CHK("cmd", 32'h0, lo)
    host.rd(16'h1801, lo); `CHK("wlow", 32'h0, lo)
    host.rd(16'h1806, lo); `CHK("unmapped", 32'h0, lo)
    host.wr(16'h1800, 32'hFFFFFFF8);
    host.rd(16'h1800, lo); `CHK("cmd ro", 32'h0, lo)
    host.rd(16'h1805, lo); `CHK("idle", 32'h0, lo)
    host.wr(16'h1801, AL);
    host.rd(16'h1801, lo); `CHK("wlow rb", AL, lo)
  endtask
  // Slot order is the table's choice, so either order is accepted
  task t_fill;
    host.make(AL, AH);
    host.make(BL, BH | 32'hFE000000);
    host.find(32'h2, lo, hi);
    host.rd(16'h1805, l2); `CHK("found", 32'h4, l2)
    host.find(32'h1, l2, h2);
    ok = (lo == AL && hi == AH && l2 == BL && h2 == BH) ||
      (lo == BL && hi == BH && l2 == AL && h2 == AH);
    `CHK("pair", 1'b1, ok)
    host.find(32'h1, lo, hi);
    host.rd(16'h1805, lo); `CHK("end", 32'h8, lo)
  endtask
  task t_remove;
    host.make(AL, 32'h00010ABC);
    host.make(BL, 32'h01420002);
    host.find(32'h2, lo, hi);
    `CHK("left low", BL, lo)
    `CHK("port", 32'h01420002, hi)
    host.find(32'h1, l2, h2);
    host.rd(16'h1805, l2); `CHK("gone", 32'h8, l2)
  endtask
  // Busy outputs lag the status flags by one clock
  task t_busy;
    host.wr(16'h1800, 32'h00000002);
    repeat (2) @(posedge clock);
    `CHK("search busy", 1'b1, sb)
    host.poll(1);
    host.wr(16'h1800, 32'h00000000);
    host.wr(16'h1800, 32'h00000004);
    repeat (2) @(posedge clock);
    `CHK("make busy", 1'b1, mb)
    @(posedge clock);
    `CHK("make done", 1'b0, mb)
    host.wr(16'h1800, 32'h00000000);
  endtask
  initial begin
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    t_reset;
    t_fill;
    t_remove;
    t_busy;
    end_of_test();
  end
endmodule // address_table_manual_access_test
